/* File: asc_pkg.sv */
// Constants, field layout and state types for the serial command front end
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package asc_pkg;

  // Command byte layout
  localparam int CMD_BITS = 8;
  localparam int START_POS = 7;
  localparam int SEL_HI_POS = 6;
  localparam int SEL_MID_POS = 5;
  localparam int SEL_LO_POS = 4;
  localparam int POL_POS = 3;
  localparam int TYPE_POS = 2;
  localparam int MODE_HI_POS = 1;
  localparam int MODE_LO_POS = 0;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // Result word: ten decisions plus two sub-bits, MSB first
  localparam int RESULT_BITS = 12;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic [3:0] RESULT_COUNT = 4'hc;

  // Link bit counter: start bit is count 1, last command bit count 8
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_START = 4'h1;
  localparam logic [3:0] CNT_LAST_BEFORE = 4'h7;
  localparam logic [3:0] CNT_RESTART_OK = 4'hf;

  // Power and clock mode field
  typedef enum logic [1:0] {
    MODE_FULL_PD = 2'b00,
    MODE_FAST_PD = 2'b01,
    MODE_INT_CLK = 2'b10,
    MODE_EXT_CLK = 2'b11
  } asc_mode_e;

  // Command receiver states
  typedef enum logic [1:0] {
    RX_WAIT = 2'b00,
    RX_CMD = 2'b01,
    RX_BUSY = 2'b10
  } asc_rx_state_e;

endpackage

/* File: asc_link_if.sv */
// Carrier between the command receiver, the result sender and the system side
`timescale 1ns/1ps
interface asc_link_if;
  logic cmd_done;
  logic cmd_toggle;
  logic [7:0] cmd_byte;

  modport rx (output cmd_done, output cmd_toggle, output cmd_byte);
  modport tx (input cmd_done, input cmd_byte);
  modport sys (input cmd_toggle, input cmd_byte);
endinterface

/* File: asc_link_rx.sv */
// Rising-edge command receiver on the serial clock
`timescale 1ns/1ps
module asc_link_rx (
  input wire logic sclk,
  input wire logic rstn,
  input wire logic link_clr_n,
  input wire logic din,
  asc_link_if.rx link
);

  asc_pkg::asc_rx_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shreg_q, shreg_d;
  logic done_q, done_d;
  logic tgl_q, tgl_d;
  logic [7:0] hold_q, hold_d;

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shreg_d = shreg_q;
    done_d = 1'b0;
    tgl_d = tgl_q;
    hold_d = hold_q;
    unique case (state_q)
      asc_pkg::RX_WAIT: begin
        if (din) begin // Zeros fall through untouched
          shreg_d = {shreg_q[6:0], din}; // Start bit lands in bit 7 after 7 more
          cnt_d = asc_pkg::CNT_START;
          state_d = asc_pkg::RX_CMD;
        end
      end
      asc_pkg::RX_CMD: begin
        shreg_d = {shreg_q[6:0], din}; // One bit per rising edge
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == asc_pkg::CNT_LAST_BEFORE) begin
          done_d = 1'b1; // In external clock mode the sender starts on the next falling edge
          tgl_d = ~tgl_q; // Only a complete command reaches the system side
          hold_d = {shreg_q[6:0], din}; // Complete byte kept for the slow side
          state_d = asc_pkg::RX_BUSY;
        end
      end
      asc_pkg::RX_BUSY: begin
        // New start accepted while B5 is on the output, giving 15 clocks per conversion
        if (cnt_q != asc_pkg::CNT_RESTART_OK) begin
          cnt_d = cnt_q + 4'h1;
        end else if (din) begin
          shreg_d = {shreg_q[6:0], din};
          cnt_d = asc_pkg::CNT_START;
          state_d = asc_pkg::RX_CMD;
        end
      end
      default: state_d = asc_pkg::RX_WAIT;
    endcase
  end

  //----------------------------------------------------------------------------
  // Registers; select high clears a partial command
  //----------------------------------------------------------------------------
  always_ff @(posedge sclk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      state_q <= asc_pkg::RX_WAIT;
      cnt_q <= 4'h0;
      shreg_q <= asc_pkg::CMD_RESET;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
      done_q <= done_d;
    end
  end

  // Toggle and held byte survive select high; byte stays put for a whole conversion
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      tgl_q <= 1'b0;
      hold_q <= asc_pkg::CMD_RESET;
    end else begin
      tgl_q <= tgl_d;
      hold_q <= hold_d;
    end
  end

  assign link.cmd_done = done_q;
  assign link.cmd_toggle = tgl_q;
  assign link.cmd_byte = hold_q; // Shift register moves again at the next start

endmodule // asc_link_rx

/* File: asc_link_tx.sv */
// Falling-edge strobe and result sender on the serial clock
`timescale 1ns/1ps
module asc_link_tx (
  input wire logic sclk,
  input wire logic link_clr_n,
  input wire logic [11:0] result_word,
  asc_link_if.tx link,
  output logic dout,
  output logic dout_oe,
  output logic conversion_strobe,
  output logic conversion_strobe_oe
);

  logic strobe_q, strobe_d;
  logic dout_q, dout_d;
  logic oe_q;
  logic [11:0] shift_q, shift_d;
  logic [3:0] left_q, left_d;
  logic ext_mode;

  assign ext_mode = link.cmd_byte[asc_pkg::MODE_HI_POS:asc_pkg::MODE_LO_POS]
                    == asc_pkg::MODE_EXT_CLK;

  //----------------------------------------------------------------------------
  // Next state: strobe, then twelve decisions MSB first
  //----------------------------------------------------------------------------
  always_comb begin
    strobe_d = 1'b0;
    dout_d = 1'b0;
    shift_d = shift_q;
    left_d = left_q;
    if (link.cmd_done && ext_mode) begin
      strobe_d = 1'b1; // One period ahead of the MSB
      shift_d = result_word;
      left_d = asc_pkg::RESULT_COUNT;
    end else if (left_q != 4'h0) begin
      dout_d = shift_q[asc_pkg::RESULT_BITS-1];
      shift_d = {shift_q[10:0], 1'b0};
      left_d = left_q - 4'h1;
    end
  end

  //----------------------------------------------------------------------------
  // Registers, all launched on falling edges only
  //----------------------------------------------------------------------------
  always_ff @(negedge sclk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      strobe_q <= 1'b0;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
      shift_q <= asc_pkg::RESULT_RESET;
      left_q <= 4'h0;
    end else begin
      strobe_q <= strobe_d;
      dout_q <= dout_d;
      oe_q <= 1'b1;
      shift_q <= shift_d;
      left_q <= left_d;
    end
  end

  assign dout = dout_q;
  assign dout_oe = oe_q;
  assign conversion_strobe = strobe_q;
  assign conversion_strobe_oe = oe_q;

endmodule // asc_link_tx

/* File: asc_top.sv */
// Serial command front end: link logic, clock crossings and command decode
`timescale 1ns/1ps
module asc_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [11:0] result_word,
  input wire logic result_load,
  output logic dout,
  output logic dout_oe,
  output logic conversion_strobe,
  output logic conversion_strobe_oe,
  output logic conv_start,
  output logic [2:0] channel_pos,
  output logic [2:0] channel_neg,
  output logic neg_is_ground,
  output logic polarity_select,
  output logic input_type_select,
  output logic [1:0] power_clock_mode,
  output logic power_down_full,
  output logic power_down_fast,
  output logic [7:0] conversion_command_byte
);

  //----------------------------------------------------------------------------
  // Link-side signals
  //----------------------------------------------------------------------------
  asc_link_if link ();

  logic link_clr_n;

  // Reset clears all the link logic, select high all but its toggle and held byte; no edge is needed for it
  assign link_clr_n = rstn & ~cs_n;

  //----------------------------------------------------------------------------
  // Command receiver and result sender
  //----------------------------------------------------------------------------
  asc_link_rx u_rx (
    .sclk(sclk),
    .rstn(rstn),
    .link_clr_n(link_clr_n),
    .din(din),
    .link(link.rx)
  );

  logic [11:0] res_copy_q;

  asc_link_tx u_tx (
    .sclk(sclk),
    .link_clr_n(link_clr_n),
    .result_word(res_copy_q),
    .link(link.tx),
    .dout(dout),
    .dout_oe(dout_oe),
    .conversion_strobe(conversion_strobe),
    .conversion_strobe_oe(conversion_strobe_oe)
  );

  //----------------------------------------------------------------------------
  // Result word hand-off, system side
  //----------------------------------------------------------------------------
  logic [11:0] res_hold_q, res_hold_d;
  logic res_tgl_q, res_tgl_d;

  // Hold word stays still until the next load, so the link copy is clean
  always_comb begin
    res_hold_d = res_hold_q;
    res_tgl_d = res_tgl_q;
    if (clk_en && result_load) begin
      res_hold_d = result_word;
      res_tgl_d = ~res_tgl_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      res_hold_q <= asc_pkg::RESULT_RESET;
      res_tgl_q <= 1'b0;
    end else begin
      res_hold_q <= res_hold_d;
      res_tgl_q <= res_tgl_d;
    end
  end

  //----------------------------------------------------------------------------
  // Result word hand-off, link side
  //----------------------------------------------------------------------------
  logic res_s1_q, res_s2_q, res_s3_q;
  logic res_s1_d, res_s2_d, res_s3_d;
  logic [11:0] res_copy_d;

  // Toggle through two flops; the word is taken only after it has settled
  always_comb begin
    res_s1_d = res_tgl_q;
    res_s2_d = res_s1_q;
    res_s3_d = res_s2_q;
    res_copy_d = res_copy_q;
    if (res_s2_q != res_s3_q) begin
      res_copy_d = res_hold_q;
    end
  end

  // Clock may stop between frames; a word loaded then is picked up later
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      res_s1_q <= 1'b0;
      res_s2_q <= 1'b0;
      res_s3_q <= 1'b0;
      res_copy_q <= asc_pkg::RESULT_RESET;
    end else begin
      res_s1_q <= res_s1_d;
      res_s2_q <= res_s2_d;
      res_s3_q <= res_s3_d;
      res_copy_q <= res_copy_d;
    end
  end

  //----------------------------------------------------------------------------
  // Command event crossing into the system clock
  //----------------------------------------------------------------------------
  logic cmd_s1_q, cmd_s2_q, cmd_s3_q;
  logic cmd_s1_d, cmd_s2_d, cmd_s3_d;
  logic cmd_event;

  always_comb begin
    cmd_s1_d = cmd_s1_q;
    cmd_s2_d = cmd_s2_q;
    cmd_s3_d = cmd_s3_q;
    if (clk_en) begin
      cmd_s1_d = link.cmd_toggle;
      cmd_s2_d = cmd_s1_q;
      cmd_s3_d = cmd_s2_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_s1_q <= 1'b0;
      cmd_s2_q <= 1'b0;
      cmd_s3_q <= 1'b0;
    end else begin
      cmd_s1_q <= cmd_s1_d;
      cmd_s2_q <= cmd_s2_d;
      cmd_s3_q <= cmd_s3_d;
    end
  end

  // Byte is held on the link until the next complete command, 15 serial clocks on
  assign cmd_event = clk_en && (cmd_s2_q != cmd_s3_q);

  //----------------------------------------------------------------------------
  // Command capture and field decode
  //----------------------------------------------------------------------------
  logic [7:0] cmd_q, cmd_d;
  logic start_q, start_d;
  logic [2:0] pos_q, pos_d;
  logic [2:0] neg_q, neg_d;
  logic gnd_q, gnd_d;
  logic pol_q, pol_d;
  logic sgl_q, sgl_d;
  asc_pkg::asc_mode_e mode_q, mode_d;
  logic pd_full_q, pd_full_d;
  logic pd_fast_q, pd_fast_d;
  logic sel_hi, sel_mid, sel_lo;

  // Decode follows the captured byte; an all-ones byte needs no special case
  always_comb begin
    cmd_d = cmd_q;
    start_d = 1'b0;
    if (cmd_event) begin
      cmd_d = link.cmd_byte;
      start_d = 1'b1; // Only a complete command starts a conversion
    end
    sel_hi = cmd_d[asc_pkg::SEL_HI_POS];
    sel_mid = cmd_d[asc_pkg::SEL_MID_POS];
    sel_lo = cmd_d[asc_pkg::SEL_LO_POS];
    pol_d = cmd_d[asc_pkg::POL_POS]; // One is unipolar
    sgl_d = cmd_d[asc_pkg::TYPE_POS]; // One is single-ended
    mode_d = asc_pkg::asc_mode_e'(cmd_d[asc_pkg::MODE_HI_POS:asc_pkg::MODE_LO_POS]);
    pos_d = {sel_mid, sel_lo, sel_hi};
    if (sgl_d) begin
      neg_d = 3'h0;
      gnd_d = 1'b1;
    end else begin
      neg_d = {sel_mid, sel_lo, ~sel_hi}; // Pair partner; hi picks the sign
      gnd_d = 1'b0;
    end
    pd_full_d = 1'b0;
    pd_fast_d = 1'b0;
    unique case (mode_d)
      asc_pkg::MODE_FULL_PD: pd_full_d = 1'b1;
      asc_pkg::MODE_FAST_PD: pd_fast_d = 1'b1;
      asc_pkg::MODE_INT_CLK: pd_full_d = 1'b0;
      asc_pkg::MODE_EXT_CLK: pd_fast_d = 1'b0; // No power-down between runs
    endcase
  end

  // Registers only; clock enable freezes them through their own update enable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= asc_pkg::CMD_RESET;
      start_q <= 1'b0;
      pos_q <= 3'h0;
      neg_q <= 3'h0;
      gnd_q <= 1'b0;
      pol_q <= 1'b0;
      sgl_q <= 1'b0;
      mode_q <= asc_pkg::MODE_FULL_PD;
      pd_full_q <= 1'b0;
      pd_fast_q <= 1'b0;
    end else if (clk_en) begin
      cmd_q <= cmd_d;
      start_q <= start_d;
      pos_q <= pos_d;
      neg_q <= neg_d;
      gnd_q <= gnd_d;
      pol_q <= pol_d;
      sgl_q <= sgl_d;
      mode_q <= mode_d;
      pd_full_q <= pd_full_d;
      pd_fast_q <= pd_fast_d;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign conv_start = start_q;
  assign channel_pos = pos_q;
  assign channel_neg = neg_q;
  assign neg_is_ground = gnd_q;
  assign polarity_select = pol_q;
  assign input_type_select = sgl_q;
  assign power_clock_mode = mode_q;
  assign power_down_full = pd_full_q;
  assign power_down_fast = pd_fast_q;
  assign conversion_command_byte = cmd_q;

endmodule // asc_top

/* File: asc_checker.sv */
// Concurrent checks on the serial command front end ports
`timescale 1ns/1ps
module asc_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [11:0] result_word,
  input wire logic result_load,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic conversion_strobe,
  input wire logic conversion_strobe_oe,
  input wire logic conv_start,
  input wire logic [2:0] channel_pos,
  input wire logic [2:0] channel_neg,
  input wire logic neg_is_ground,
  input wire logic polarity_select,
  input wire logic input_type_select,
  input wire logic [1:0] power_clock_mode,
  input wire logic power_down_full,
  input wire logic power_down_fast,
  input wire logic [7:0] conversion_command_byte
);
  // ------
  // Helpers
  // ------
  logic seen_q, seen_d, dout_r_q, strb_r_q;
  logic [7:0] b;
  assign b = conversion_command_byte;
  // Decode is meaningless until one command arrived
  assign seen_d = seen_q | conv_start;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) seen_q <= 1'b0;
    else seen_q <= seen_d;
  end
  // Link outputs as seen in the high phase
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) {dout_r_q, strb_r_q} <= 2'b00;
    else {dout_r_q, strb_r_q} <= {dout, conversion_strobe};
  end
  // Fourteen quiet falling edges after a strobe
  sequence s_quiet14;
    (!conversion_strobe) [*8] ##1 (!conversion_strobe) [*6];
  endsequence

  strobe_space_a: assert property (@(negedge sclk) disable iff (!rstn || cs_n)
    conversion_strobe |=> s_quiet14) else $error("strobe repeated too soon");
  link_edge_a: assert property (@(negedge sclk) disable iff (!rstn || cs_n)
    dout == dout_r_q && conversion_strobe == strb_r_q) else $error("link moved on rise");
  link_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cs_n |-> !dout_oe && !conversion_strobe_oe && !dout) else $error("link driven");
  start_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_start |=> (!conv_start) [*4]) else $error("start pulse too long");
  chan_single_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    seen_q && $stable(b) && b[2] |-> channel_pos == {b[5], b[4], b[6]} &&
    channel_neg == 3'h0 && neg_is_ground) else $error("single channel wrong");
  chan_diff_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    seen_q && $stable(b) && !b[2] |-> channel_pos == {b[5], b[4], b[6]} &&
    channel_neg == {b[5], b[4], ~b[6]} && !neg_is_ground) else $error("pair wrong");
  fields_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    seen_q && $stable(b) |-> polarity_select == b[3] && input_type_select == b[2] &&
    power_clock_mode == b[1:0]) else $error("fields wrong");
  power_flags_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    seen_q && $stable(b) |-> power_down_full == (b[1:0] == 2'b00) &&
    power_down_fast == (b[1:0] == 2'b01)) else $error("power flags wrong");
endmodule // asc_checker

bind asc_top asc_checker u_chk (.sys_clk, .rstn, .clk_en, .sclk, .cs_n, .din,
  .result_word, .result_load, .dout, .dout_oe, .conversion_strobe,
  .conversion_strobe_oe, .conv_start, .channel_pos, .channel_neg, .neg_is_ground,
  .polarity_select, .input_type_select, .power_clock_mode, .power_down_full,
  .power_down_fast, .conversion_command_byte);

/* File: asc_host_model.sv */
// Host serial master model driving the command link
`timescale 1ns/1ps
module asc_host_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic conversion_strobe
);
  // Clock parked low, chip deselected between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Select change with half a period of margin either side
  task automatic select(input logic lvl);
    #16;
    cs_n = lvl;
    if (lvl) din = ~din; // Released line shows no stale value
    #16;
  endtask
  // Mode zero: data set while clock low, lines read before the rise
  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rd,
    output logic [31:0] rs);
    rd = 32'h0;
    rs = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      din = tx[i];
      #16;
      rd = {rd[30:0], dout};
      rs = {rs[30:0], conversion_strobe};
      sclk = 1'b1;
      #16;
      sclk = 1'b0;
    end
  endtask
endmodule // asc_host_model

/* File: adc_serial_command_interface_tb_top.sv */
// Testbench for the serial command front end
`timescale 1ns/1ps
module adc_serial_command_interface_tb_top;
  logic sys_clk = 1'b0;
  logic rstn;
  logic clk_en;
  logic [11:0] result_word;
  logic result_load;
  logic sclk, cs_n, din, dout, dout_oe, conversion_strobe, conversion_strobe_oe;
  logic conv_start, neg_is_ground, polarity_select, input_type_select;
  logic power_down_full, power_down_fast;
  logic [2:0] channel_pos, channel_neg;
  logic [1:0] power_clock_mode;
  logic [7:0] conversion_command_byte;
  logic [31:0] rd, rs;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_start = 0;
  int s0;

  always #50 sys_clk = ~sys_clk;
  // Count start pulses seen on the system side
  always @(posedge sys_clk) if (conv_start === 1'b1) n_start++;

  asc_top dut (.sys_clk, .rstn, .clk_en, .sclk, .cs_n, .din, .result_word,
    .result_load, .dout, .dout_oe, .conversion_strobe, .conversion_strobe_oe,
    .conv_start, .channel_pos, .channel_neg, .neg_is_ground, .polarity_select,
    .input_type_select, .power_clock_mode, .power_down_full, .power_down_fast,
    .conversion_command_byte);
  asc_host_model host (.sclk, .cs_n, .din, .dout, .conversion_strobe);

  // ------
  // Tasks
  // ------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Result word handed over well before the frame uses it
  task automatic load(input logic [11:0] w);
    @(posedge sys_clk);
    result_word <= w;
    result_load <= 1'b1;
    @(posedge sys_clk);
    result_load <= 1'b0;
    repeat (4) @(posedge sys_clk);
    s0 = n_start;
  endtask
  // Expected decode, packed like the observed fields
  function automatic logic [31:0] dec_exp(input logic [7:0] c);
    return {11'h0, c[5], c[4], c[6], c[2] ? 3'h0 : {c[5], c[4], ~c[6]}, c[2], c[3],
      c[2], c[1:0], c[1:0] == 2'b00, c[1:0] == 2'b01, c};
  endfunction
  task automatic chk_dec(input logic [7:0] c, input int starts);
    repeat (6) @(posedge sys_clk);
    chk("decode", dec_exp(c), {11'h0, channel_pos, channel_neg, neg_is_ground,
      polarity_select, input_type_select, power_clock_mode, power_down_full,
      power_down_fast, conversion_command_byte});
    chk("starts", s0 + starts, n_start);
  endtask
  // One frame: command, then two zero bytes clocking the result back
  task automatic convert(input logic [7:0] c, input int nz, input logic [11:0] w);
    logic ext;
    ext = c[1:0] == 2'b11;
    load(w);
    host.select(1'b0);
    host.shift({8'h0, c, 16'h0}, 24 + nz, rd, rs);
    host.select(1'b1);
    chk_dec(c, 1);
    chk("result", ext ? {17'h0, w, 3'h0} : 32'h0, rd);
    chk("strobe", ext ? 32'h8000 : 32'h0, rs);
  endtask

  // ------
  // Tests
  // ------
  initial begin
    rstn <= 1'b0;
    clk_en <= 1'b1;
    result_word <= 12'h000;
    result_load <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("reset", 32'h0, {dout, dout_oe, conversion_strobe, conversion_strobe_oe,
      conv_start, channel_pos, channel_neg, power_clock_mode, power_down_full,
      power_down_fast, conversion_command_byte});
    for (int i = 0; i < 16; i++) begin
      convert({1'b1, i[2:0], i[3], i[0] ~^ i[1], 2'b11}, i % 4,
        {i[3:0], ~i[3:0], i[3:0]} ^ 12'ha5c);
    end
    $display("test external done");
    for (int m = 0; m < 3; m++) begin
      convert({6'h2f, m[1:0]}, 1, 12'hfff);
    end
    $display("test modes done");
    load(12'h3c1);
    host.select(1'b0);
    host.shift(32'hb, 4, rd, rs);
    host.select(1'b1);
    chk_dec(8'hbe, 0);
    convert(8'h9f, 0, 12'h5a3);
    $display("test abort done");
    load(12'h5a3);
    host.select(1'b0);
    host.shift(32'h0, 16, rd, rs);
    host.select(1'b1);
    chk_dec(8'h9f, 0);
    chk("idle strobe", 32'h0, rs);
    $display("test idle done");
    // Frozen system side takes neither load nor command until enabled again
    @(posedge sys_clk);
    clk_en <= 1'b0;
    load(12'h0f0);
    host.select(1'b0);
    host.shift({8'h0, 8'hd3, 16'h0}, 24, rd, rs);
    host.select(1'b1);
    chk("frozen byte", 32'h9f, conversion_command_byte);
    chk("frozen result", {17'h0, 12'h5a3, 3'h0}, rd);
    chk("frozen strobe", 32'h8000, rs);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    chk_dec(8'hd3, 1);
    $display("test enable done");
    load(12'hc3e);
    host.select(1'b0);
    host.shift({17'h0, 8'hb7, 7'h00}, 15, rd, rs);
    chk("first result", {26'h0, 6'h30}, rd);
    chk("first strobe", 32'h40, rs);
    host.shift({8'h0, 8'hcf, 16'h0}, 24, rd, rs);
    chk("drive enable", 32'h3, {dout_oe, conversion_strobe_oe});
    host.select(1'b1);
    chk_dec(8'hcf, 2);
    chk("second result", {8'h0, 6'h3e, 3'h0, 12'hc3e, 3'h0}, rd);
    chk("second strobe", 32'h8000, rs);
    $display("test back to back done");
    conclude();
  end

  // Whole run needs well under a millisecond
  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end
endmodule // adc_serial_command_interface_tb_top
